// ---- core/tmh_trigger_ctrl.v ----
// Trigger mode and holdoff controller: qualifies trigger events and issues
// acquisition start pulses. Assumes the trigger detector runs on the same clock
// and registers are written over a plain strobe port on that clock.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "tmh_map.vh"

module tmh_trigger_ctrl #(
  parameter [31:0] HOLD_TIME_RST = `TMH_HOLD_TIME_RST_CYC,
  parameter [31:0] RAND_MAX_RST = `TMH_RAND_MAX_RST_CYC,
  parameter [31:0] RAND_MIN_RST = `TMH_RAND_MIN_RST_CYC,
  parameter [31:0] AUTO_TIME_RST = `TMH_AUTO_TIME_RST_CYC,
  parameter [31:0] HSCALE_RST = `TMH_HSCALE_RST_CYC,
  parameter [31:0] AUTO_MAX = `TMH_AUTO_MAX_CYC,
  parameter [35:0] AUTO_TO_DIVS = `TMH_AUTO_TO_DIVS,
  parameter [35:0] FREE_TICKS = `TMH_FREE_TICKS
) (
  input wire core_clk_in,         // Core clock, 10 MHz.
  input wire rst_in,              // Asynchronous reset, active high.
  input wire ce_in,               // Clock enable; low freezes all state.
  input wire [7:0] addr_in,       // Register byte address.
  input wire [31:0] wr_data_in,   // Register write data.
  input wire wr_en_in,            // Write strobe, one cycle.
  input wire rd_en_in,            // Read strobe, one cycle.
  output reg [31:0] rd_data_out,  // Read data, valid the cycle after rd_en_in.
  input wire trig_event_in,       // Real trigger event pulse from the detector.
  output reg acq_start_out,       // Acquisition start pulse.
  output reg acq_self_out,        // Start was self-generated (auto or free-run).
  output reg acq_forced_out,      // Start was caused by a force write.
  output reg holdoff_busy_out     // Timed holdoff currently suppressing triggers.
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [`TMH_CTRL_WIDTH-1:0] ctrl_r;
  reg [31:0] hold_time_r;
  reg [30:0] hold_events_r;
  reg [31:0] rand_max_r;
  reg [31:0] rand_min_r;
  reg [31:0] auto_scale_r;
  reg [31:0] hscale_r;
  reg [31:0] auto_time_r;
  reg force_pend_r;
  reg [31:0] hold_cnt_r;
  reg [31:0] ev_cnt_r;
  reg [35:0] to_cnt_r;
  reg [31:0] lfsr_r;
  reg [15:0] acq_count_r;

  wire [1:0] trig_mode;
  wire [2:0] hold_mode;
  wire hold_allowed;
  wire hold_on;
  wire timed_mode;
  wire events_mode;
  wire timed_busy;
  wire [31:0] ev_need;
  wire ev_reach;
  wire real_seen;
  wire real_ok;
  wire [35:0] auto_timeout;
  wire [35:0] self_lim;
  wire self_due;
  wire self_ok;
  wire start;
  wire wr_ctrl;
  wire wr_force;

  assign trig_mode = ctrl_r[`TMH_CTRL_MODE_MSB:`TMH_CTRL_MODE_LSB];
  assign hold_mode = ctrl_r[`TMH_CTRL_HOLD_MSB:`TMH_CTRL_HOLD_LSB];
  assign wr_ctrl = wr_en_in && (addr_in == `TMH_OFS_CTRL);
  assign wr_force = wr_en_in && (addr_in == `TMH_OFS_FORCE) && wr_data_in[`TMH_FORCE_BIT];

  // --------------------------------------------------------------------------
  // Holdoff qualification
  // --------------------------------------------------------------------------
  // External, serial and sequence triggering bypass holdoff entirely.
  assign hold_allowed = !ctrl_r[`TMH_CTRL_SRC_NOHOLD_BIT] && !ctrl_r[`TMH_CTRL_SEQ_BIT];
  assign hold_on = hold_allowed && (hold_mode != `TMH_HOLD_OFF);
  assign events_mode = hold_on && (hold_mode == `TMH_HOLD_EVENTS);
  assign timed_mode = hold_on && !events_mode;
  assign timed_busy = timed_mode && (hold_cnt_r != 32'h0000_0000);

  // A programmed count of zero is treated as one, so no event is ever lost.
  assign ev_need = (hold_events_r == 31'h0000_0000) ? 32'h0000_0001 : {1'b0, hold_events_r};
  assign ev_reach = ((ev_cnt_r + 32'h0000_0001) >= ev_need);

  assign real_seen = trig_event_in && (trig_mode != `TMH_MODE_FREE);
  assign real_ok = real_seen && !timed_busy && (!events_mode || ev_reach);

  // --------------------------------------------------------------------------
  // Self-trigger timing
  // --------------------------------------------------------------------------
  // The auto timeout spans a full screen of the horizontal scale; free-run uses
  // a fixed short interval that must stay below it.
  assign auto_timeout = {4'h0, hscale_r} * AUTO_TO_DIVS;
  assign self_lim = (trig_mode == `TMH_MODE_FREE) ? FREE_TICKS : auto_timeout;
  assign self_due = (trig_mode != `TMH_MODE_NORMAL) && ((to_cnt_r + 36'h0_0000_0001) >= self_lim);
  // A real trigger in the same cycle wins over the timeout.
  assign self_ok = self_due && !real_ok;
  assign start = real_ok || self_ok || force_pend_r;

  // --------------------------------------------------------------------------
  // Random draw and holdoff period
  // --------------------------------------------------------------------------
  reg [31:0] rand_span;
  reg [47:0] rand_prod;
  reg [31:0] rand_draw;
  reg [31:0] period;
  reg [31:0] hold_cnt_nxt;

  always @* begin
    rand_span = 32'h0000_0000;
    rand_prod = 48'h0000_0000_0000;
    if (rand_min_r >= rand_max_r) begin
      rand_draw = rand_max_r;
    end else begin
      rand_span = rand_max_r - rand_min_r;
      rand_prod = {32'h0000_0000, lfsr_r[15:0]} * {16'h0000, rand_span};
      rand_draw = rand_min_r + rand_prod[47:16];
    end
  end

  always @* begin
    case (hold_mode)
      `TMH_HOLD_TIME: period = hold_time_r;
      `TMH_HOLD_RANDOM: period = rand_draw;
      `TMH_HOLD_AUTO: period = auto_time_r;
      default: period = 32'h0000_0000;
    endcase
  end

  always @* begin
    if (start && timed_mode) begin
      hold_cnt_nxt = (period == 32'h0000_0000) ? 32'h0000_0000 : period - 32'h0000_0001;
    end else if (!timed_mode) begin
      hold_cnt_nxt = 32'h0000_0000;
    end else if (hold_cnt_r != 32'h0000_0000) begin
      hold_cnt_nxt = hold_cnt_r - 32'h0000_0001;
    end else begin
      hold_cnt_nxt = hold_cnt_r;
    end
  end

  // --------------------------------------------------------------------------
  // Auto holdoff time
  // --------------------------------------------------------------------------
  // The factor is held in thousandths, so the product is divided back by the
  // scale divisor and clamped to the legal time range.
  reg [63:0] auto_prod;
  reg [63:0] auto_quot;
  reg [31:0] auto_time_nxt;

  always @* begin
    auto_prod = {32'h0000_0000, hscale_r} * {32'h0000_0000, auto_scale_r};
    auto_quot = auto_prod / `TMH_SCALE_DIV;
    if (auto_quot < `TMH_AUTO_MIN_CYC) begin
      auto_time_nxt = `TMH_AUTO_MIN_CYC;
    end else if (auto_quot > {32'h0000_0000, AUTO_MAX}) begin
      auto_time_nxt = AUTO_MAX;
    end else begin
      auto_time_nxt = auto_quot[31:0];
    end
  end

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= `TMH_CTRL_RST;
      hold_time_r <= HOLD_TIME_RST;
      hold_events_r <= `TMH_HOLD_EVENTS_RST;
      rand_max_r <= RAND_MAX_RST;
      rand_min_r <= RAND_MIN_RST;
      auto_scale_r <= `TMH_AUTO_SCALE_RST;
      hscale_r <= HSCALE_RST;
      force_pend_r <= 1'b0;
    end else if (ce_in) begin
      force_pend_r <= wr_force;
      if (wr_ctrl) begin
        ctrl_r <= wr_data_in[`TMH_CTRL_WIDTH-1:0];
      end
      if (wr_en_in) begin
        case (addr_in)
          `TMH_OFS_HOLD_TIME: hold_time_r <= wr_data_in;
          `TMH_OFS_HOLD_EVENTS: hold_events_r <= wr_data_in[30:0];
          `TMH_OFS_RAND_MAX: rand_max_r <= wr_data_in;
          `TMH_OFS_RAND_MIN: rand_min_r <= wr_data_in;
          `TMH_OFS_AUTO_SCALE: auto_scale_r <= wr_data_in;
          `TMH_OFS_HSCALE: hscale_r <= wr_data_in;
          default: hold_time_r <= hold_time_r;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Trigger engine state
  // --------------------------------------------------------------------------
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_cnt_r <= 32'h0000_0000;
      ev_cnt_r <= 32'h0000_0000;
      to_cnt_r <= 36'h0_0000_0000;
      lfsr_r <= `TMH_LFSR_SEED;
      auto_time_r <= AUTO_TIME_RST;
      acq_count_r <= 16'h0000;
    end else if (ce_in) begin
      hold_cnt_r <= hold_cnt_nxt;
      auto_time_r <= auto_time_nxt;
      // The generator runs every cycle so each acquisition sees a new draw.
      lfsr_r <= lfsr_r[0] ? ((lfsr_r >> 1) ^ `TMH_LFSR_TAPS) : (lfsr_r >> 1);
      if (start) begin
        ev_cnt_r <= 32'h0000_0000;
        to_cnt_r <= 36'h0_0000_0000;
        acq_count_r <= acq_count_r + 16'h0001;
      end else begin
        if (real_seen && events_mode) begin
          ev_cnt_r <= ev_cnt_r + 32'h0000_0001;
        end
        if (to_cnt_r != 36'hF_FFFF_FFFF) begin
          to_cnt_r <= to_cnt_r + 36'h0_0000_0001;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acq_start_out <= 1'b0;
      acq_self_out <= 1'b0;
      acq_forced_out <= 1'b0;
      holdoff_busy_out <= 1'b0;
    end else if (ce_in) begin
      acq_start_out <= start;
      acq_self_out <= self_ok && !force_pend_r;
      acq_forced_out <= force_pend_r;
      holdoff_busy_out <= timed_mode && (hold_cnt_nxt != 32'h0000_0000);
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  // Read data stand for exactly one cycle; unmapped and write-only words read zero.
  reg [31:0] rd_mux;

  always @* begin
    case (addr_in)
      `TMH_OFS_CTRL: rd_mux = {25'h000_0000, ctrl_r};
      `TMH_OFS_HOLD_TIME: rd_mux = hold_time_r;
      `TMH_OFS_HOLD_EVENTS: rd_mux = {1'b0, hold_events_r};
      `TMH_OFS_RAND_MAX: rd_mux = rand_max_r;
      `TMH_OFS_RAND_MIN: rd_mux = rand_min_r;
      `TMH_OFS_AUTO_SCALE: rd_mux = auto_scale_r;
      `TMH_OFS_HSCALE: rd_mux = hscale_r;
      `TMH_OFS_AUTO_TIME: rd_mux = auto_time_r;
      `TMH_OFS_STATUS: rd_mux = {acq_count_r, 13'h0000, hold_on, (ev_cnt_r != 32'h0000_0000), timed_busy};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 32'h0000_0000;
    end else if (ce_in) begin
      rd_data_out <= rd_en_in ? rd_mux : 32'h0000_0000;
    end
  end

endmodule // tmh_trigger_ctrl

// ---- dv/testbench.sv ----
// Self-checking bench for the trigger controller with a stand-in detector.
// Assumes short counts: scale 20 ticks, 2 divisions timeout, free-run every 4.
`timescale 1ns/100ps
`include "tmh_map.vh"
module testbench;
  reg core_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg [7:0] addr_in = 8'h00;
  reg [31:0] wr_data_in = 32'h0000_0000;
  reg wr_en_in = 1'b0;
  reg rd_en_in = 1'b0;
  reg ce_in = 1'b1;
  reg [7:0] gap = 8'h00;
  wire [31:0] rd_data_out;
  wire trig_event_in, acq_start_out, acq_self_out, acq_forced_out, holdoff_busy_out;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #50 core_clk_in = ~core_clk_in;
  // Hold time and auto time keep their defaults: the first is written before use, the second
  // is recomputed from the short scale one cycle after reset.
  tmh_trigger_ctrl #(
    .RAND_MAX_RST(32'h0000_0014), .RAND_MIN_RST(32'h0000_000A), .HSCALE_RST(32'h0000_0014),
    .AUTO_TO_DIVS(36'h0_0000_0002), .FREE_TICKS(36'h0_0000_0004)
  ) DUT (
    .core_clk_in, .rst_in, .ce_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in,
    .rd_data_out, .trig_event_in, .acq_start_out, .acq_self_out, .acq_forced_out, .holdoff_busy_out
  );
  tmh_trig_src u_src (.core_clk_in, .rst_in, .gap_in(gap), .ev_out(trig_event_in));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge core_clk_in);
    wr_en_in <= 1'b0;
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge core_clk_in);
    rd_en_in <= 1'b0;
    @(negedge core_clk_in);
    chk(nm, e, rd_data_out);
  endtask
  task setm(input logic [31:0] c, input logic [7:0] g);
    wr(`TMH_OFS_CTRL, c);
    gap <= g;
    repeat (4) @(posedge core_clk_in);
  endtask
  // Skips the first, possibly partial, spacing and returns a later one.
  task iv(output int n, output logic s);
    repeat (3) begin
      @(negedge core_clk_in);
      n = 1;
      while (acq_start_out !== 1'b1 && n < 300) begin
        @(negedge core_clk_in);
        n++;
      end
    end
    s = acq_self_out;
  endtask
  task t_reset;
    rc("ctrl", `TMH_OFS_CTRL, 32'h0000_0000);
    rc("events", `TMH_OFS_HOLD_EVENTS, 32'h0000_0001);
    rc("rmax", `TMH_OFS_RAND_MAX, 32'h0000_0014);
    rc("rmin", `TMH_OFS_RAND_MIN, 32'h0000_000A);
    rc("scale", `TMH_OFS_AUTO_SCALE, `TMH_AUTO_SCALE_RST);
    rc("atime", `TMH_OFS_AUTO_TIME, 32'h0000_000A);
    rc("unmapped", 8'h30, 32'h0000_0000);
    $display("test reset done");
  endtask
  task t_modes;
    int n;
    logic s;
    iv(n, s);
    chk("auto_iv", 32'h0000_0028, n);
    chk("auto_self", 1'b1, s);
    setm(32'h0000_0000, 8'h01);
    iv(n, s);
    chk("real_iv", 32'h0000_0001, n);
    chk("real_self", 1'b0, s);
    setm(32'h0000_0002, 8'h01);
    iv(n, s);
    chk("free_iv", 32'h0000_0004, n);
    chk("free_self", 1'b1, s);
    // With the enable low the free-run pulses must stop, so the start line never moves.
    @(posedge core_clk_in);
    ce_in <= 1'b0;
    @(negedge core_clk_in);
    s = acq_start_out;
    n = 0;
    repeat (20) begin
      @(negedge core_clk_in);
      if (acq_start_out !== s) n++;
    end
    @(posedge core_clk_in);
    ce_in <= 1'b1;
    chk("ce_freeze", 32'h0000_0000, n);
    setm(32'h0000_0001, 8'h00);
    n = 0;
    repeat (100) begin
      @(negedge core_clk_in);
      if (acq_start_out === 1'b1) n++;
    end
    chk("nrm_starts", 32'h0000_0000, n);
    wr(`TMH_OFS_FORCE, 32'h0000_0001);
    repeat (2) @(negedge core_clk_in);
    chk("force_start", 1'b1, acq_start_out);
    chk("force_flag", 1'b1, acq_forced_out);
    rc("force_rd", `TMH_OFS_FORCE, 32'h0000_0000);
    $display("test modes done");
  endtask
  task t_hold;
    int n;
    logic s;
    logic [31:0] c[4] = '{32'h0000_0005, 32'h0000_0025, 32'h0000_0045, 32'h0000_0001};
    logic [31:0] e[4] = '{32'h0000_000C, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001};
    wr(`TMH_OFS_HOLD_TIME, 32'h0000_000C);
    for (int i = 0; i < 4; i++) begin
      setm(c[i], 8'h01);
      iv(n, s);
      chk("hold_iv", e[i], n);
      chk("hold_busy", (i == 0), holdoff_busy_out);
    end
    wr(`TMH_OFS_HOLD_EVENTS, 32'h0000_0003);
    setm(32'h0000_0009, 8'h02);
    iv(n, s);
    chk("events_iv", 32'h0000_0006, n);
    $display("test hold done");
  endtask
  task t_rand;
    int n;
    int f;
    logic s;
    logic v;
    wr(`TMH_OFS_RAND_MIN, 32'h0000_0005);
    wr(`TMH_OFS_RAND_MAX, 32'h0000_000F);
    setm(32'h0000_000D, 8'h01);
    iv(f, s);
    v = 1'b0;
    repeat (4) begin
      iv(n, s);
      chk("rand_rng", 1'b1, n >= 5 && n <= 15);
      if (n != f) v = 1'b1;
    end
    chk("rand_new", 1'b1, v);
    wr(`TMH_OFS_RAND_MIN, 32'h0000_0014);
    wr(`TMH_OFS_RAND_MAX, 32'h0000_0008);
    iv(n, s);
    chk("rand_inv", 32'h0000_0008, n);
    $display("test rand done");
  endtask
  task t_autoh;
    int n;
    logic s;
    wr(`TMH_OFS_AUTO_SCALE, 32'h0000_05DC);
    rc("atime", `TMH_OFS_AUTO_TIME, 32'h0000_001E);
    wr(`TMH_OFS_AUTO_TIME, 32'h0000_0005);
    rc("atime_ro", `TMH_OFS_AUTO_TIME, 32'h0000_001E);
    setm(32'h0000_0011, 8'h01);
    iv(n, s);
    chk("autoh_iv", 32'h0000_001E, n);
    $display("test autoh done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    t_reset;
    t_modes;
    t_hold;
    t_rand;
    t_autoh;
    final_report;
  end
endmodule // testbench

// ---- dv/tmh_trig_src.sv ----
// Stand-in for the trigger event detector in front of the controller.
// Assumes the controller's clock and reset; a gap of zero keeps it silent.
`timescale 1ns/100ps
module tmh_trig_src (
  input wire core_clk_in, // Core clock.
  input wire rst_in, // Reset, active high.
  input wire [7:0] gap_in, // Cycles from one event to the next.
  output reg ev_out // One-cycle event pulse.
);
  reg [7:0] cnt_r;
  // A gap of one holds the line high, which the controller counts as one event per cycle.
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 8'h00;
      ev_out <= 1'b0;
    end else if (gap_in == 8'h00) begin
      cnt_r <= 8'h00;
      ev_out <= 1'b0;
    end else begin
      ev_out <= (cnt_r == 8'h00);
      cnt_r <= (cnt_r + 8'h01 >= gap_in) ? 8'h00 : cnt_r + 8'h01;
    end
  end
endmodule // tmh_trig_src

// ---- dv/tmh_trigger_ctrl_properties.sv ----
// Port checker for the trigger controller, attached by bind.
// Assumes the clock enable stays high while traffic is checked.
`timescale 1ns/100ps
`include "tmh_map.vh"
module tmh_trigger_ctrl_chk #(
  parameter [31:0] HOLD_TIME_RST = `TMH_HOLD_TIME_RST_CYC
) (
  input wire core_clk_in, // Core clock.
  input wire rst_in, // Async reset.
  input wire ce_in, // Clock enable.
  input wire [7:0] addr_in, // Address.
  input wire [31:0] wr_data_in, // Write data.
  input wire wr_en_in, // Write strobe.
  input wire rd_en_in, // Read strobe.
  input wire [31:0] rd_data_out, // Read data.
  input wire trig_event_in, // Real event.
  input wire acq_start_out, // Start pulse.
  input wire acq_self_out, // Self start.
  input wire acq_forced_out, // Forced start.
  input wire holdoff_busy_out // Holdoff busy.
);
  reg [6:0] ctl_r;
  reg [31:0] hld_r;
  wire wr_ok = ce_in && wr_en_in;
  // Shadow copies let mode-dependent properties work without internal probes.
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_r <= `TMH_CTRL_RST;
      hld_r <= HOLD_TIME_RST;
    end else begin
      if (wr_ok && addr_in == `TMH_OFS_CTRL) ctl_r <= wr_data_in[6:0];
      if (wr_ok && addr_in == `TMH_OFS_HOLD_TIME) hld_r <= wr_data_in;
    end
  end
  wire nrm = ctl_r[1:0] == `TMH_MODE_NORMAL;
  wire fre = ctl_r[1:0] == `TMH_MODE_FREE;
  wire hnone = ctl_r[4:2] == `TMH_HOLD_OFF || ctl_r[5] || ctl_r[6];
  wire htime = ctl_r[4:2] == `TMH_HOLD_TIME && !ctl_r[5] && !ctl_r[6];
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_force_wr;
    wr_ok && addr_in == `TMH_OFS_FORCE && wr_data_in[0];
  endsequence
  sequence s_force_ans;
    acq_start_out && acq_forced_out;
  endsequence
  sequence s_nrm;
    nrm && $past(nrm);
  endsequence
  property p_self_tag; acq_self_out |-> acq_start_out; endproperty
  a_self_tag: assert property (p_self_tag) else $error("self flag without start");
  property p_forced_tag; acq_forced_out |-> acq_start_out; endproperty
  a_forced_tag: assert property (p_forced_tag) else $error("forced flag without start");
  property p_force_start; s_force_wr |-> ##2 s_force_ans; endproperty
  a_force_start: assert property (p_force_start) else $error("force gave no start");
  property p_force_rd; ce_in && rd_en_in && addr_in == `TMH_OFS_FORCE |=> rd_data_out == 32'h0000_0000; endproperty
  a_force_rd: assert property (p_force_rd) else $error("force register readable");
  property p_nrm_noself; s_nrm |-> !acq_self_out; endproperty
  a_nrm_noself: assert property (p_nrm_noself) else $error("self start in normal mode");
  property p_nrm_cause; s_nrm ##0 acq_start_out |-> $past(trig_event_in) || acq_forced_out; endproperty
  a_nrm_cause: assert property (p_nrm_cause) else $error("start without cause");
  property p_free_ign; fre && $past(fre) && acq_start_out |-> acq_self_out || acq_forced_out; endproperty
  a_free_ign: assert property (p_free_ign) else $error("real start in free mode");
  property p_real_acc; nrm && hnone && trig_event_in |=> acq_start_out && !acq_self_out; endproperty
  a_real_acc: assert property (p_real_acc) else $error("event not accepted");
  property p_time_busy;
    s_nrm ##0 (htime && $stable(ctl_r) && $stable(hld_r) && hld_r >= 32'h0000_0002 && acq_start_out)
      |-> holdoff_busy_out;
  endproperty
  a_time_busy: assert property (p_time_busy) else $error("holdoff not started");
endmodule // tmh_trigger_ctrl_chk
bind tmh_trigger_ctrl tmh_trigger_ctrl_chk #(.HOLD_TIME_RST(HOLD_TIME_RST)) u_chk (
  .core_clk_in, .rst_in, .ce_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in,
  .rd_data_out, .trig_event_in, .acq_start_out, .acq_self_out, .acq_forced_out,
  .holdoff_busy_out
);

// ---- shared/tmh_map.vh ----
// Register map, field layout, reset values and timing counts of the trigger
// mode and holdoff controller. Assumes a 10 MHz core clock; all times held in
// registers are counts of 100 ns ticks.
`ifndef TMH_MAP_VH
`define TMH_MAP_VH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define TMH_CLK_PERIOD_NS 100

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TMH_OFS_CTRL 8'h00
`define TMH_OFS_FORCE 8'h04
`define TMH_OFS_HOLD_TIME 8'h08
`define TMH_OFS_HOLD_EVENTS 8'h0C
`define TMH_OFS_RAND_MAX 8'h10
`define TMH_OFS_RAND_MIN 8'h14
`define TMH_OFS_AUTO_SCALE 8'h18
`define TMH_OFS_HSCALE 8'h1C
`define TMH_OFS_AUTO_TIME 8'h20
`define TMH_OFS_STATUS 8'h24

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define TMH_CTRL_MODE_LSB 0
`define TMH_CTRL_MODE_MSB 1
`define TMH_CTRL_HOLD_LSB 2
`define TMH_CTRL_HOLD_MSB 4
`define TMH_CTRL_SRC_NOHOLD_BIT 5
`define TMH_CTRL_SEQ_BIT 6
`define TMH_CTRL_WIDTH 7
`define TMH_FORCE_BIT 0

// Trigger modes.
`define TMH_MODE_AUTO 2'h0
`define TMH_MODE_NORMAL 2'h1
`define TMH_MODE_FREE 2'h2

// Holdoff methods.
`define TMH_HOLD_OFF 3'h0
`define TMH_HOLD_TIME 3'h1
`define TMH_HOLD_EVENTS 3'h2
`define TMH_HOLD_RANDOM 3'h3
`define TMH_HOLD_AUTO 3'h4

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define TMH_CTRL_RST 7'h00
`define TMH_HOLD_EVENTS_RST 31'h0000_0001
`define TMH_AUTO_SCALE_RST 32'h0000_01F4
`define TMH_SCALE_DIV 1000
`define TMH_HOLD_TIME_RST_NS 1000000
`define TMH_RAND_MAX_RST_NS 2000000
`define TMH_RAND_MIN_RST_NS 1000000
`define TMH_AUTO_TIME_RST_NS 1000000
`define TMH_HSCALE_RST_NS 2000000
`define TMH_AUTO_MIN_NS 100
`define TMH_AUTO_MAX_MS 10000
`define TMH_HOLD_TIME_RST_CYC (`TMH_HOLD_TIME_RST_NS / `TMH_CLK_PERIOD_NS)
`define TMH_RAND_MAX_RST_CYC (`TMH_RAND_MAX_RST_NS / `TMH_CLK_PERIOD_NS)
`define TMH_RAND_MIN_RST_CYC (`TMH_RAND_MIN_RST_NS / `TMH_CLK_PERIOD_NS)
`define TMH_AUTO_TIME_RST_CYC (`TMH_AUTO_TIME_RST_NS / `TMH_CLK_PERIOD_NS)
`define TMH_HSCALE_RST_CYC (`TMH_HSCALE_RST_NS / `TMH_CLK_PERIOD_NS)
`define TMH_AUTO_MIN_CYC ((`TMH_AUTO_MIN_NS + `TMH_CLK_PERIOD_NS - 1) / `TMH_CLK_PERIOD_NS)
`define TMH_AUTO_MAX_CYC (`TMH_AUTO_MAX_MS * (1000000 / `TMH_CLK_PERIOD_NS))
`define TMH_AUTO_TO_DIVS 10
`define TMH_FREE_TICKS 16
`define TMH_LFSR_SEED 32'hACE1_2468
`define TMH_LFSR_TAPS 32'h8020_0003

`endif
